// File: pkg/cgr_pkg.sv
// constants, types and register layout of the clock guard and reset flag block
package cgr_pkg;

    // register map: printed offset is an index, byte address is four times it
    localparam logic [7:0] STATUS_IDX = 8'h2b;
    localparam logic [31:0] STATUS_ADDR = {22'h000000, STATUS_IDX, 2'b00};

    // status field positions
    localparam int WDG_BIT = 0;
    localparam int BKP_BIT = 1;
    localparam int IE_BIT = 2;
    localparam int UV_BIT = 4;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;

    // timing at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int RST_PULSE_NS = 20000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_DELAY_CYC = 4096;
    localparam int FETCH_CYC = 2;
    localparam int SAFE_PERIOD_CYC = 64;
    localparam int FILT_CYC = 2;
    localparam int CNT_W = 13;

    // oscillator option codes
    typedef enum logic [2:0] {
        CGR_OSC_EXT,
        CGR_OSC_RES0,
        CGR_OSC_RES1,
        CGR_OSC_RES2,
        CGR_OSC_RES3,
        CGR_OSC_EXT_RC,
        CGR_OSC_INT_RC
    } cgr_osc_t;
    localparam int OSC_N = 7;

    // reset sequence phases
    typedef enum logic [1:0] {
        CGR_SEQ_DRIVE,
        CGR_SEQ_DELAY,
        CGR_SEQ_FETCH,
        CGR_SEQ_RUN
    } cgr_seq_t;

endpackage

// File: src/cgr_clock_guard.sv
// clock guard, reset sequencing, reset cause flags and status register on ahb-lite
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module cgr_clock_guard
(
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // option byte straps
    input wire logic [2:0] opt_osc_sel,
    input wire logic opt_guard_en,
    input wire logic opt_uv_en,
    // reset sources
    input wire logic uv_low,
    input wire logic wdg_underflow,
    input wire logic ext_reset_seen,
    // reset pin, open drain
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // core side
    output logic core_reset_n,
    output logic vector_fetch,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic core_irq_mask,
    output logic guard_irq,
    output logic wake_from_wait,
    // oscillator side, levels sampled on hclk
    input wire logic main_osc_lvl,
    input wire logic backup_osc_lvl,
    output logic [6:0] osc_enable,
    output logic backup_osc_enable,
    output logic sys_clk_out,
    output logic backup_selected,
    output logic [1:0] reset_cause
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        cgr_pkg::cgr_seq_t seq;
        logic [cgr_pkg::CNT_W-1:0] seq_cnt;
        logic [2:0] osc_sel;
        logic guard_en;
        logic uv_en;
        logic uv_flag;
        logic wdg_flag;
        logic ie;
        logic bkp_flag;
        logic on_backup;
        logic switching;
        logic main_filt;
        logic main_prev;
        logic [1:0] filt_cnt;
        logic [6:0] miss_cnt;
        logic clk_out;
        logic wr_pend;
        logic [31:0] rdata;
    } cgr_state_t;

    cgr_state_t st_ff;
    cgr_state_t nxt_st;

    logic in_reset;
    logic addr_hit;
    logic take;
    logic [7:0] status_view;
    logic main_ok;
    logic want_backup;
    logic cur_lvl;
    logic new_lvl;
    logic guard_run;

    // ****************************************
    // combinational helpers
    // ****************************************

    // any reset source keeps the sequence in its drive phase
    assign in_reset = uv_low | wdg_underflow | ext_reset_seen;

    // clock guard stops entirely in halt and when option turns it off
    assign guard_run = st_ff.guard_en & ~halt_mode;

    assign take = hsel & hready & (htrans == cgr_pkg::HTRANS_NONSEQ
        || htrans == cgr_pkg::HTRANS_SEQ);
    assign addr_hit = (haddr == cgr_pkg::STATUS_ADDR);

    // main clock counts as good once the filter passes it again
    assign main_ok = (st_ff.miss_cnt < 7'(cgr_pkg::SAFE_PERIOD_CYC));
    assign want_backup = guard_run & ~main_ok;

    // source levels before and after a pending switch
    assign cur_lvl = st_ff.on_backup ? backup_osc_lvl : st_ff.main_filt;
    assign new_lvl = st_ff.on_backup ? st_ff.main_filt : backup_osc_lvl;

    // status byte, reserved bits tied low
    always_comb
    begin
        status_view = cgr_pkg::STATUS_RST;
        status_view[cgr_pkg::UV_BIT] = st_ff.uv_flag;
        status_view[cgr_pkg::IE_BIT] = st_ff.ie;
        status_view[cgr_pkg::BKP_BIT] = st_ff.bkp_flag & st_ff.guard_en;
        status_view[cgr_pkg::WDG_BIT] = st_ff.wdg_flag;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        nxt_st = st_ff;

        // reset sequence: drive pin, internal delay, vector fetch, run
        unique case (st_ff.seq)
            cgr_pkg::CGR_SEQ_DRIVE:
            begin
                if (st_ff.seq_cnt != '0)
                begin
                    nxt_st.seq_cnt = st_ff.seq_cnt - 1'b1;
                end
                else if (!in_reset && reset_pin_in)
                begin
                    nxt_st.seq = cgr_pkg::CGR_SEQ_DELAY;
                    nxt_st.seq_cnt = cgr_pkg::CNT_W'(cgr_pkg::INT_DELAY_CYC - 1);
                    // options are caught once the pin is released
                    nxt_st.osc_sel = opt_osc_sel;
                    nxt_st.guard_en = opt_guard_en;
                    nxt_st.uv_en = opt_uv_en;
                end
            end
            cgr_pkg::CGR_SEQ_DELAY:
            begin
                if (st_ff.seq_cnt == '0)
                begin
                    nxt_st.seq = cgr_pkg::CGR_SEQ_FETCH;
                    nxt_st.seq_cnt = cgr_pkg::CNT_W'(cgr_pkg::FETCH_CYC - 1);
                end
                else
                begin
                    nxt_st.seq_cnt = st_ff.seq_cnt - 1'b1;
                end
            end
            cgr_pkg::CGR_SEQ_FETCH:
            begin
                if (st_ff.seq_cnt == '0)
                begin
                    nxt_st.seq = cgr_pkg::CGR_SEQ_RUN;
                end
                else
                begin
                    nxt_st.seq_cnt = st_ff.seq_cnt - 1'b1;
                end
            end
            cgr_pkg::CGR_SEQ_RUN:
            begin
                nxt_st.seq_cnt = '0;
            end
        endcase

        // a new reset event restarts the sequence from any phase
        if (in_reset)
        begin
            nxt_st.seq = cgr_pkg::CGR_SEQ_DRIVE;
            if (wdg_underflow)
            begin
                nxt_st.seq_cnt = cgr_pkg::CNT_W'(cgr_pkg::RST_PULSE_CYC);
            end
            else if (st_ff.seq != cgr_pkg::CGR_SEQ_DRIVE)
            begin
                nxt_st.seq_cnt = '0;
            end
        end

        // spike filter: level must hold FILT_CYC + 2 samples to pass
        nxt_st.main_prev = main_osc_lvl;
        if (main_osc_lvl != st_ff.main_prev)
        begin
            nxt_st.filt_cnt = '0;
        end
        else if (st_ff.filt_cnt != 2'(cgr_pkg::FILT_CYC))
        begin
            nxt_st.filt_cnt = st_ff.filt_cnt + 1'b1;
        end
        else
        begin
            nxt_st.main_filt = main_osc_lvl;
        end
        if (!st_ff.guard_en)
        begin
            // no filtering without the guard, raw clock passes
            nxt_st.main_filt = main_osc_lvl;
        end

        // loss detector counts samples without a filtered main edge
        if (guard_run)
        begin
            if (nxt_st.main_filt != st_ff.main_filt)
            begin
                nxt_st.miss_cnt = '0;
            end
            else if (main_ok)
            begin
                nxt_st.miss_cnt = st_ff.miss_cnt + 1'b1;
            end
        end

        // glitch-free switch: leave current source on its low phase,
        // hold low, then join the new source on its low phase
        if (st_ff.guard_en && !halt_mode)
        begin
            if (!st_ff.switching && (want_backup != st_ff.on_backup))
            begin
                nxt_st.switching = 1'b1;
            end
            if (st_ff.switching)
            begin
                if (!st_ff.clk_out && !new_lvl)
                begin
                    nxt_st.on_backup = ~st_ff.on_backup;
                    nxt_st.switching = 1'b0;
                end
                // a main clock stuck high is dead, so dropping it cannot cut a pulse
                nxt_st.clk_out = st_ff.clk_out & cur_lvl
                    & ~(want_backup & ~st_ff.on_backup);
            end
            else
            begin
                nxt_st.clk_out = cur_lvl;
            end
        end
        else if (!st_ff.guard_en)
        begin
            nxt_st.on_backup = 1'b0;
            nxt_st.switching = 1'b0;
            nxt_st.clk_out = main_osc_lvl;
        end

        // ahb data phase and register effects
        nxt_st.wr_pend = take & hwrite & addr_hit;
        if (take && !hwrite)
        begin
            nxt_st.rdata = addr_hit ? {24'h000000, status_view} : 32'h00000000;
        end

        // the status register is frozen in halt
        if (!halt_mode)
        begin
            if (st_ff.wr_pend)
            begin
                nxt_st.ie = hwdata[cgr_pkg::IE_BIT];
                if (!hwdata[cgr_pkg::UV_BIT])
                begin
                    nxt_st.uv_flag = 1'b0;
                end
                if (!hwdata[cgr_pkg::WDG_BIT])
                begin
                    nxt_st.wdg_flag = 1'b0;
                end
            end
            // read clears the backup flag only once main is back
            if (take && !hwrite && addr_hit && !st_ff.on_backup && !want_backup)
            begin
                nxt_st.bkp_flag = 1'b0;
            end
            // hardware sets win over software clears
            if (want_backup)
            begin
                nxt_st.bkp_flag = 1'b1;
            end
            if (wdg_underflow)
            begin
                nxt_st.wdg_flag = 1'b1;
            end
            if (uv_low && st_ff.uv_en)
            begin
                nxt_st.uv_flag = 1'b1;
                nxt_st.wdg_flag = 1'b0;
            end
        end
        if (!st_ff.guard_en)
        begin
            nxt_st.bkp_flag = 1'b0;
        end

        // any reset wake restarts guard config from reset values
        if (in_reset)
        begin
            nxt_st.ie = 1'b0;
            nxt_st.bkp_flag = 1'b0;
            nxt_st.miss_cnt = '0;
            nxt_st.on_backup = 1'b0;
            nxt_st.switching = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************

    // power-up lands in the drive phase; flags start clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '{
                seq: cgr_pkg::CGR_SEQ_DRIVE,
                seq_cnt: '0,
                osc_sel: '0,
                guard_en: 1'b0,
                uv_en: 1'b0,
                uv_flag: 1'b0,
                wdg_flag: 1'b0,
                ie: 1'b0,
                bkp_flag: 1'b0,
                on_backup: 1'b0,
                switching: 1'b0,
                main_filt: 1'b0,
                main_prev: 1'b0,
                filt_cnt: '0,
                miss_cnt: '0,
                clk_out: 1'b0,
                wr_pend: 1'b0,
                rdata: '0
            };
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;

    // pin pulled low in the drive and internal delay phases; the drive phase lets
    // go once its pulse is done, so an outside holder of the pin can be seen
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = ((st_ff.seq == cgr_pkg::CGR_SEQ_DRIVE)
        & ((st_ff.seq_cnt != '0) | in_reset))
        | (st_ff.seq == cgr_pkg::CGR_SEQ_DELAY) | uv_low;
    assign core_reset_n = (st_ff.seq == cgr_pkg::CGR_SEQ_RUN)
        | (st_ff.seq == cgr_pkg::CGR_SEQ_FETCH);
    assign vector_fetch = (st_ff.seq == cgr_pkg::CGR_SEQ_FETCH);

    // one-hot oscillator enable; rc sources rest during reset,
    // resonators and the external input keep going
    genvar gi;
    generate
        for (gi = 0; gi < cgr_pkg::OSC_N; gi++)
        begin : g_osc
            assign osc_enable[gi] = (st_ff.osc_sel == 3'(gi))
                & ((gi < int'(cgr_pkg::CGR_OSC_EXT_RC))
                | (st_ff.seq == cgr_pkg::CGR_SEQ_RUN));
        end
    endgenerate

    // backup oscillator idles in halt and when the guard is off
    assign backup_osc_enable = guard_run;
    assign sys_clk_out = st_ff.clk_out;
    assign backup_selected = st_ff.on_backup;

    // irq needs flag, enable, guard option and open core mask
    assign guard_irq = st_ff.bkp_flag & st_ff.ie & st_ff.guard_en
        & ~core_irq_mask & ~halt_mode;
    // wake from wait regardless of mask; never from halt
    assign wake_from_wait = st_ff.bkp_flag & st_ff.ie & st_ff.guard_en
        & wait_mode & ~halt_mode;

    // cause decode: 1x undervoltage, 01 watchdog, 00 pin
    assign reset_cause = st_ff.uv_flag ? 2'b10 : {1'b0, st_ff.wdg_flag};

endmodule

// File: test/cgr_osc_partner.sv
// oscillator sources and reset pin as seen from the clock guard block
`timescale 1ns/10ps
module cgr_osc_partner
(
    input wire logic hclk,
    input wire logic [1:0] osc_mode,
    input wire logic reset_pin_oe,
    input wire logic backup_osc_enable,
    output logic main_osc_lvl,
    output logic backup_osc_lvl,
    output logic reset_pin_in
);
    // ********************
    // sources and pin
    // ********************
    logic [3:0] div_ff = 4'h0;

    // pull-up on the open-drain pin: high unless the block pulls it low
    assign reset_pin_in = ~reset_pin_oe;

    // known levels before the first edge
    initial
    begin
        main_osc_lvl = 1'b0;
        backup_osc_lvl = 1'b0;
    end

    // mode 0 runs at clk/8, 1 stops dead, 2 flips every sample so the filter must block it
    always @(posedge hclk)
    begin
        div_ff <= div_ff + 4'h1;
        case (osc_mode)
            2'h0: main_osc_lvl <= div_ff[2];
            2'h2: main_osc_lvl <= ~main_osc_lvl;
            default: main_osc_lvl <= main_osc_lvl;
        endcase
        // slow safe source, still when switched off
        backup_osc_lvl <= backup_osc_enable & div_ff[3];
    end
endmodule

// File: test/cgr_clock_guard_asserts.sv
// port checker of the clock guard and reset flag block
`timescale 1ns/10ps
module cgr_clock_guard_chk
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic opt_guard_en,
    input wire logic uv_low,
    input wire logic wdg_underflow,
    input wire logic reset_pin_oe,
    input wire logic core_reset_n,
    input wire logic vector_fetch,
    input wire logic halt_mode,
    input wire logic core_irq_mask,
    input wire logic guard_irq,
    input wire logic main_osc_lvl,
    input wire logic backup_selected,
    input wire logic [1:0] reset_cause
);
    // ********************
    // helper counters
    // ********************
    logic [15:0] oe_run_ff;
    logic [7:0] stuck_ff;
    logic main_q_ff;

    // run length of pin drive, and of a frozen main clock while the core runs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oe_run_ff <= 16'h0000;
            stuck_ff <= 8'h00;
            main_q_ff <= 1'b0;
        end
        else
        begin
            main_q_ff <= main_osc_lvl;
            oe_run_ff <= reset_pin_oe ? oe_run_ff + {15'h0000, ~&oe_run_ff} : 16'h0000;
            // halt stops the guard, so a halt restarts the count
            if (main_osc_lvl != main_q_ff || !core_reset_n || halt_mode)
                stuck_ff <= 8'h00;
            else
                stuck_ff <= stuck_ff + {7'h00, ~&stuck_ff};
        end
    end

    // ********************
    // properties
    // ********************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_drive;
        (reset_pin_oe && !core_reset_n) [*8];
    endsequence
    sequence s_fetch;
        vector_fetch ##1 vector_fetch ##1 !vector_fetch;
    endsequence

    property p_uv_pin; uv_low |-> reset_pin_oe; endproperty
    property p_wdg_pin; wdg_underflow |=> s_drive; endproperty
    property p_fetch; $rose(vector_fetch) |-> s_fetch; endproperty
    property p_delay;
        $rose(vector_fetch) |-> core_reset_n && oe_run_ff >= 16'(cgr_pkg::INT_DELAY_CYC);
    endproperty
    property p_cause; reset_cause != 2'h3; endproperty
    property p_rd_res; hrdata[31:8] == 24'h0 && hrdata[7:5] == 3'h0 && !hrdata[3]; endproperty
    property p_irq; guard_irq |-> !core_irq_mask && !halt_mode && opt_guard_en; endproperty
    property p_off; !opt_guard_en |-> !backup_selected; endproperty
    property p_bkp; stuck_ff == 8'd100 && opt_guard_en |-> backup_selected; endproperty

    a_uv_pin: assert property (p_uv_pin) else $error("pin free in undervoltage");
    a_wdg_pin: assert property (p_wdg_pin) else $error("pin free after underflow");
    a_fetch: assert property (p_fetch) else $error("fetch not two cycles");
    a_delay: assert property (p_delay) else $error("internal delay too short");
    a_cause: assert property (p_cause) else $error("bad reset cause code");
    a_rd_res: assert property (p_rd_res) else $error("reserved bits read set");
    a_irq: assert property (p_irq) else $error("irq while masked or halted");
    a_off: assert property (p_off) else $error("backup while guard off");
    a_bkp: assert property (p_bkp) else $error("no backup on dead clock");
endmodule

bind cgr_clock_guard cgr_clock_guard_chk u_chk (.hclk, .hresetn, .hrdata, .opt_guard_en,
    .uv_low, .wdg_underflow, .reset_pin_oe, .core_reset_n, .vector_fetch, .halt_mode,
    .core_irq_mask, .guard_irq, .main_osc_lvl, .backup_selected, .reset_cause);

// File: test/tb_clock_guard_reset_flags.sv
// self-checking bench of the clock guard and reset flag block
`timescale 1ns/10ps
module tb_clock_guard_reset_flags;
    // ********************
    // signals and instances
    // ********************
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, uv_low = 1'b0;
    logic wdg_underflow = 1'b0, halt_mode = 1'b0, wait_mode = 1'b0, core_irq_mask = 1'b1;
    logic opt_guard_en = 1'b1, hreadyout, hresp, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic core_reset_n, vector_fetch, guard_irq, wake_from_wait, main_osc_lvl, backup_osc_lvl;
    logic backup_osc_enable, sys_clk_out, backup_selected;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic [1:0] htrans = 2'h0, osc_mode = 2'h0, reset_cause;
    logic [2:0] opt_osc_sel = 3'h1;
    logic [6:0] osc_enable;
    int n_mismatch = 0, num_checks = 0, n;
    localparam logic [31:0] SR = cgr_pkg::STATUS_ADDR;

    cgr_clock_guard u_cgr_clock_guard (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(1'b1), .hwdata, .hrdata, .hreadyout, .hresp, .opt_osc_sel,
        .opt_guard_en, .opt_uv_en(1'b1), .uv_low, .wdg_underflow, .ext_reset_seen(1'b0),
        .reset_pin_in, .reset_pin_out, .reset_pin_oe, .core_reset_n, .vector_fetch, .halt_mode,
        .wait_mode, .core_irq_mask, .guard_irq, .wake_from_wait, .main_osc_lvl, .backup_osc_lvl,
        .osc_enable, .backup_osc_enable, .sys_clk_out, .backup_selected, .reset_cause);
    cgr_osc_partner u_cgr_osc_partner (.hclk, .osc_mode, .reset_pin_oe, .backup_osc_enable,
        .main_osc_lvl, .backup_osc_lvl, .reset_pin_in);

    // 40 MHz bus clock
    always #12.5 hclk = ~hclk;

    // ********************
    // tasks
    // ********************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // a wait that runs out ends the run as a mismatch
    task automatic bail(input string what);
        $display("Error %s expected done seen timeout", what);
        n_mismatch++;
        tally_and_finish();
    endtask

    task automatic wait_rdy();
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            bail("bus ready");
    endtask

    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= cgr_pkg::HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdat = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    // waits for the core to enter and then leave reset
    task automatic wait_run();
        for (n = 0; core_reset_n !== 1'b0 && n < 10; n++)
            @(posedge hclk);
        for (n = 0; (core_reset_n !== 1'b1 || vector_fetch !== 1'b0) && n < 12000; n++)
            @(posedge hclk);
        if (n >= 12000)
            bail("core run");
    endtask

    // options are only changed while the block is held in reset
    task automatic do_reset(input logic [2:0] sel, input logic g);
        hresetn <= 1'b0;
        opt_osc_sel <= sel;
        opt_guard_en <= g;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wait_run();
    endtask

    task automatic wdg_pulse();
        wdg_underflow <= 1'b1;
        @(posedge hclk);
        wdg_underflow <= 1'b0;
        @(posedge hclk);
        chk("osc enable in reset", 32'h2, {25'h0, osc_enable});
        for (n = 0; reset_pin_oe === 1'b1 && n < 2000; n++)
            @(posedge hclk);
        chk("pin drive", 32'h1, {31'h0, n >= cgr_pkg::RST_PULSE_CYC});
        wait_run();
    endtask

    task automatic wait_bkp(input logic v);
        for (n = 0; backup_selected !== v && n < 300; n++)
            @(posedge hclk);
        chk("backup selected", {31'h0, v}, {31'h0, backup_selected});
    endtask

    // ********************
    // main sequence
    // ********************
    initial
    begin
        for (int i = 0; i < 7; i++)
        begin
            do_reset(3'((i + 2) % 7), 1'b1);
            chk("osc enable", 32'h1 << ((i + 2) % 7), {25'h0, osc_enable});
        end
        rd(SR, 32'h00, "status after pin reset");
        chk("cause", 32'h0, {30'h0, reset_cause});
        xfer(1'b1, SR, 32'hff);
        rd(SR, 32'h04, "status rw");
        rd(SR + 32'h4, 32'h0, "unmapped");
        $display("test options and registers done");
        wdg_pulse();
        rd(SR, 32'h01, "status after watchdog");
        chk("cause", 32'h1, {30'h0, reset_cause});
        xfer(1'b1, SR, 32'h00);
        rd(SR, 32'h00, "watchdog flag cleared");
        uv_low <= 1'b1;
        @(posedge hclk);
        chk("pin in undervoltage", 32'h1, {31'h0, reset_pin_oe});
        repeat (20) @(posedge hclk);
        uv_low <= 1'b0;
        wait_run();
        rd(SR, 32'h10, "status after undervoltage");
        chk("cause", 32'h2, {30'h0, reset_cause});
        wdg_pulse();
        rd(SR, 32'h11, "undervoltage flag kept");
        chk("cause", 32'h2, {30'h0, reset_cause});
        xfer(1'b1, SR, 32'h00);
        rd(SR, 32'h00, "flags cleared");
        $display("test reset causes done");
        xfer(1'b1, SR, 32'h04);
        core_irq_mask <= 1'b0;
        osc_mode <= 2'h1;
        wait_bkp(1'b1);
        repeat (2) @(posedge hclk);
        chk("irq", 32'h1, {31'h0, guard_irq});
        core_irq_mask <= 1'b1;
        wait_mode <= 1'b1;
        @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, guard_irq});
        chk("wake", 32'h1, {31'h0, wake_from_wait});
        wait_mode <= 1'b0;
        halt_mode <= 1'b1;
        @(posedge hclk);
        chk("irq in halt", 32'h0, {31'h0, guard_irq});
        xfer(1'b1, SR, 32'h00);
        halt_mode <= 1'b0;
        @(posedge hclk);
        rd(SR, 32'h06, "status frozen in halt");
        repeat (120) @(posedge hclk);
        osc_mode <= 2'h0;
        wait_bkp(1'b0);
        rd(SR, 32'h06, "flag before clearing read");
        rd(SR, 32'h04, "flag after clearing read");
        osc_mode <= 2'h2;
        wait_bkp(1'b1);
        osc_mode <= 2'h0;
        wait_bkp(1'b0);
        $display("test clock guard done");
        do_reset(3'h1, 1'b0);
        osc_mode <= 2'h1;
        xfer(1'b1, SR, 32'h04);
        repeat (200) @(posedge hclk);
        chk("backup with guard off", 32'h0, {31'h0, backup_selected});
        chk("irq with guard off", 32'h0, {31'h0, guard_irq});
        rd(SR, 32'h04, "status with guard off");
        osc_mode <= 2'h0;
        $display("test guard option off done");
        tally_and_finish();
    end
endmodule
